// file: src/fppc_pkg.sv
// Purpose: Shared constants and types of the flash program/protect controller
// Assumes: AXI4-Lite register slave with 32-bit data, one system clock
// Notes:   Register offsets are byte addresses on the slave
`default_nettype none
package fppc_pkg;
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FADDR_W    = 13;

  // Register byte offsets
  localparam logic [7:0] OFF_FLASH_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFF_OPTION            = 8'h04;
  localparam logic [7:0] OFF_STATUS            = 8'h08;
  localparam logic [7:0] OFF_RX_DATA           = 8'h0C;
  localparam logic [7:0] OFF_FLASH_ADDR        = 8'h10;
  localparam logic [7:0] OFF_LATCH_DATA        = 8'h14;

  // Control/status register
  localparam logic [7:0] FCS_RESET  = 8'h00;
  localparam logic [7:0] KEY_FIRST  = 8'h56;
  localparam logic [7:0] KEY_SECOND = 8'hAE;
  localparam int unsigned BIT_PGM   = 0;
  localparam int unsigned BIT_LAT   = 1;
  localparam int unsigned BIT_OPT   = 2;

  // Option byte bit positions
  localparam int unsigned OPT_READ_PROT  = 0;
  localparam int unsigned OPT_WRITE_PROT = 1;
  // Pending option copy in the option register
  localparam int unsigned OPT_PEND_READ  = 4;
  localparam int unsigned OPT_PEND_WRITE = 5;

  // Status register bits
  localparam int unsigned ST_ICC      = 0;
  localparam int unsigned ST_TOOL     = 1;
  localparam int unsigned ST_BUSY     = 2;
  localparam int unsigned ST_REFUSED  = 3;
  localparam int unsigned ST_OVERRUN  = 4;
  localparam int unsigned ST_RX_VALID = 5;
  localparam int unsigned ST_UNLOCKED = 6;
  localparam int unsigned ST_RD_BLOCK = 7;

  // Flash geometry and burst limit
  localparam logic [12:0] SECTOR0_END = 13'h1000;
  localparam logic [5:0]  MAX_BURST   = 6'h20;

  // Serial entry signature, arbitrary value
  localparam logic [7:0] ENTRY_PATTERN = 8'hA5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {KEY_LOCKED, KEY_ONE, KEY_OPEN} fppc_key_type;
  typedef enum logic [1:0] {FL_IDLE, FL_MASS, FL_OP} fppc_fl_type;
  typedef enum logic [1:0] {OP_PROGRAM, OP_ERASE, OP_MASS_ERASE} fppc_op_type;

  typedef struct packed {
    logic                 req;
    fppc_op_type          kind;
    logic                 optionRow;
    logic [FADDR_W-1:0]   addr;
    logic [BYTE_W-1:0]    optData;
  } fppc_flash_cmd_type;

  typedef struct packed {
    logic               strobe;
    logic [4:0]         index;
    logic [BYTE_W-1:0]  data;
  } fppc_latch_type;
endpackage
`default_nettype wire

// file: src/fppc_fifo.sv
// Purpose: Small first-word-fall-through FIFO for received serial bytes
// Assumes: DEPTH is a power of two
// Notes:   Write and read may happen in the same cycle
`default_nettype none
module fppc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,      // System clock
  input  wire logic             rst_n,    // Synchronous reset, active low
  input  wire logic             inValid,  // Write request
  output logic                  inReady,  // Room for a word
  input  wire logic [WIDTH-1:0] inData,   // Write data
  output logic                  outValid, // Word available
  input  wire logic             outReady, // Pop request
  output logic [WIDTH-1:0]      outData,  // Head word
  output logic [$clog2(DEPTH):0] level    // Words held
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } fppc_fifo_state_type;

  fppc_fifo_state_type s_r;
  fppc_fifo_state_type s_nxt;
  logic                push;
  logic                pop;

  assign inReady  = (s_r.cnt != FULL);
  assign outValid = (s_r.cnt != '0);
  assign outData  = s_r.mem[s_r.rp];
  assign level    = s_r.cnt;
  assign push     = inValid & inReady;
  assign pop      = outReady & outValid;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = inData;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// file: src/flash_program_protect_ctrl.sv
// Purpose: Serial programming entry, flash protection and keyed flash control
// Assumes: Tool pins arrive asynchronously; flash macro answers on this clock
// Notes:   All outputs are registered; serial bytes are buffered for the loader
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module flash_program_protect_ctrl (
  input  wire logic        clk,                // System clock 250 MHz
  input  wire logic        rst_n,              // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,       // Write address
  input  wire logic        s_axi_awvalid,      // Write address valid
  output logic             s_axi_awready,      // Write address ready
  input  wire logic [31:0] s_axi_wdata,        // Write data
  input  wire logic [3:0]  s_axi_wstrb,        // Write strobes
  input  wire logic        s_axi_wvalid,       // Write data valid
  output logic             s_axi_wready,       // Write data ready
  output logic [1:0]       s_axi_bresp,        // Write response
  output logic             s_axi_bvalid,       // Write response valid
  input  wire logic        s_axi_bready,       // Write response ready
  input  wire logic [7:0]  s_axi_araddr,       // Read address
  input  wire logic        s_axi_arvalid,      // Read address valid
  output logic             s_axi_arready,      // Read address ready
  output logic [31:0]      s_axi_rdata,        // Read data
  output logic [1:0]       s_axi_rresp,        // Read response
  output logic             s_axi_rvalid,       // Read data valid
  input  wire logic        s_axi_rready,       // Read data ready
  input  wire logic        progSerialClock,    // Tool serial clock pin
  input  wire logic        progSerialData,     // Tool serial data pin
  input  wire logic        progSelect,         // Tool attached pin, high active
  input  wire logic        resetPin_n,         // Device reset pin level, low active
  input  wire logic [7:0]  optionByteIn,       // Stored option byte
  input  wire logic        flashDone,          // Flash operation complete pulse
  output logic             sysMemVector,       // Fetch system-memory reset vector
  output logic             inCircuitCommActive, // Serial session mode
  output logic             pinsReservedForTool, // Serial pins withheld from app
  output logic             readoutBlock,       // Block external memory reads
  output fppc_pkg::fppc_flash_cmd_type flashCmd, // Flash operation request
  output fppc_pkg::fppc_latch_type     latchOut  // Burst latch write
);
  typedef struct packed {
    logic [2:0]              clkSync;
    logic [1:0]              datSync;
    logic [2:0]              pinSync;
    logic [1:0]              selSync;
    logic [7:0]              entryShift;
    logic                    in_circuit_comm;
    logic                    tool;
    logic [7:0]              rxShift;
    logic [2:0]              rxCount;
    logic                    rxPending;
    logic [7:0]              rxByte;
    logic                    overrun;
    logic                    refused;
    logic                    optRow;
    logic                    latCtl;
    logic                    program_go;
    fppc_pkg::fppc_key_type  key;
    logic                    optLoaded;
    logic                    optRead;
    logic                    optWrite;
    logic                    pendRead;
    logic                    pendWrite;
    fppc_pkg::fppc_fl_type   fl;
    fppc_pkg::fppc_flash_cmd_type cmd;
    logic [5:0]              latchCount;
    fppc_pkg::fppc_latch_type latch;
    logic                    rdBlock;
    logic                    awHeld;
    logic [7:0]              awAddr;
    logic                    wHeld;
    logic [7:0]              wByte;
    logic [4:0]              wHigh;
    logic                    wLane0;
    logic                    awReady;
    logic                    wReady;
    logic                    bValid;
    logic [1:0]              bResp;
    logic                    arReady;
    logic                    rValid;
    logic [31:0]             rData;
    logic [1:0]              rResp;
  } fppc_state_type;

  fppc_state_type s_r;
  fppc_state_type s_nxt;
  logic           linkRise;
  logic           pinRelease;
  logic           fifoInReady;
  logic           fifoOutValid;
  logic [7:0]     fifoOutData;
  logic [3:0]     fifoLevel;
  logic           fifoPop;
  logic           overrunEvt;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == fppc_pkg::OFF_FLASH_CTRL_STATUS) || (a == fppc_pkg::OFF_OPTION) ||
               (a == fppc_pkg::OFF_STATUS) || (a == fppc_pkg::OFF_RX_DATA) ||
               (a == fppc_pkg::OFF_FLASH_ADDR) || (a == fppc_pkg::OFF_LATCH_DATA);
  endfunction

  fppc_fifo #(
    .WIDTH (fppc_pkg::BYTE_W),
    .DEPTH (fppc_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (s_r.rxPending),
    .inReady  (fifoInReady),
    .inData   (s_r.rxByte),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData),
    .level    (fifoLevel)
  );

  assign linkRise   = s_r.clkSync[1] & ~s_r.clkSync[2];
  assign pinRelease = s_r.pinSync[1] & ~s_r.pinSync[2];
  assign fifoPop    = s_axi_arvalid & s_r.arReady & (s_axi_araddr == fppc_pkg::OFF_RX_DATA);

  always_comb begin
    s_nxt = s_r;
    overrunEvt = 1'b0;
    s_nxt.latch.strobe = 1'b0;
    // Pin synchronisers
    s_nxt.clkSync = {s_r.clkSync[1:0], progSerialClock};
    s_nxt.datSync = {s_r.datSync[0], progSerialData};
    s_nxt.pinSync = {s_r.pinSync[1:0], resetPin_n};
    s_nxt.selSync = {s_r.selSync[0], progSelect};

    // Option byte capture after reset
    if (!s_r.optLoaded) begin
      s_nxt.optLoaded = 1'b1;
      s_nxt.optRead   = optionByteIn[fppc_pkg::OPT_READ_PROT];
      s_nxt.optWrite  = optionByteIn[fppc_pkg::OPT_WRITE_PROT];
      s_nxt.pendRead  = optionByteIn[fppc_pkg::OPT_READ_PROT];
      s_nxt.pendWrite = optionByteIn[fppc_pkg::OPT_WRITE_PROT];
    end

    // Mode entry: pattern clocked in while the reset pin is low
    if (!s_r.pinSync[1]) begin
      s_nxt.in_circuit_comm = 1'b0;
      if (linkRise) begin
        s_nxt.entryShift = {s_r.entryShift[6:0], s_r.datSync[1]};
      end
    end else if (pinRelease) begin
      s_nxt.in_circuit_comm        = (s_r.entryShift == fppc_pkg::ENTRY_PATTERN);
      s_nxt.entryShift = '0;
      s_nxt.rxCount    = '0;
    end
    s_nxt.tool = s_r.selSync[1] | s_nxt.in_circuit_comm;
    s_nxt.rdBlock = s_r.optRead & s_nxt.tool;

    // Serial byte receive while in session
    if (s_r.in_circuit_comm && s_r.pinSync[1] && linkRise) begin
      s_nxt.rxShift = {s_r.rxShift[6:0], s_r.datSync[1]};
      s_nxt.rxCount = s_r.rxCount + 3'h1;
      if (s_r.rxCount == 3'h7) begin
        if (s_r.rxPending && !fifoInReady) begin
          s_nxt.overrun = 1'b1;
          overrunEvt    = 1'b1;
        end else begin
          s_nxt.rxByte    = {s_r.rxShift[6:0], s_r.datSync[1]};
          s_nxt.rxPending = 1'b1;
        end
      end
    end
    if (s_r.rxPending && fifoInReady && !(s_nxt.rxPending && s_nxt.rxByte != s_r.rxByte)) begin
      s_nxt.rxPending = (s_r.in_circuit_comm && linkRise && s_r.rxCount == 3'h7);
    end

    // Flash operation sequencing
    case (s_r.fl)
      fppc_pkg::FL_IDLE: begin
      end
      fppc_pkg::FL_MASS: begin
        if (flashDone) begin
          s_nxt.fl = fppc_pkg::FL_OP;
          s_nxt.cmd.kind = fppc_pkg::OP_PROGRAM;
        end
      end
      fppc_pkg::FL_OP: begin
        if (flashDone) begin
          s_nxt.fl = fppc_pkg::FL_IDLE;
          s_nxt.cmd.req = 1'b0;
          s_nxt.program_go = 1'b0;
          s_nxt.latchCount = '0;
          if (s_r.cmd.optionRow) begin
            s_nxt.optRead  = s_r.pendRead;
            s_nxt.optWrite = s_r.optWrite | s_r.pendWrite;
          end
        end
      end
      default: s_nxt.fl = fppc_pkg::FL_IDLE;
    endcase

    // Register writes
    if (!s_r.awHeld && s_axi_awvalid) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (!s_r.wHeld && s_axi_wvalid) begin
      s_nxt.wHeld  = 1'b1;
      s_nxt.wByte  = s_axi_wdata[7:0];
      s_nxt.wHigh  = s_axi_wdata[12:8];
      s_nxt.wLane0 = s_axi_wstrb[0];
    end
    if (s_r.bValid && s_axi_bready) begin
      s_nxt.bValid = 1'b0;
    end
    if (s_r.awHeld && s_r.wHeld && !s_r.bValid) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp  = isMapped(s_r.awAddr) ? fppc_pkg::RESP_OKAY : fppc_pkg::RESP_SLVERR;
      if (s_r.wLane0) begin
        case (s_r.awAddr)
          fppc_pkg::OFF_FLASH_CTRL_STATUS: begin
            case (s_r.key)
              fppc_pkg::KEY_LOCKED: begin
                s_nxt.key = (s_r.wByte == fppc_pkg::KEY_FIRST) ?
                            fppc_pkg::KEY_ONE : fppc_pkg::KEY_LOCKED;
              end
              fppc_pkg::KEY_ONE: begin
                s_nxt.key = (s_r.wByte == fppc_pkg::KEY_SECOND) ?
                            fppc_pkg::KEY_OPEN : fppc_pkg::KEY_LOCKED;
              end
              fppc_pkg::KEY_OPEN: begin
                s_nxt.key = fppc_pkg::KEY_LOCKED;
                if (s_r.fl == fppc_pkg::FL_IDLE) begin
                  s_nxt.optRow = s_r.wByte[fppc_pkg::BIT_OPT];
                  s_nxt.latCtl = s_r.wByte[fppc_pkg::BIT_LAT];
                  if (s_r.wByte[fppc_pkg::BIT_PGM]) begin
                    s_nxt.cmd.optionRow = s_r.wByte[fppc_pkg::BIT_OPT];
                    s_nxt.cmd.optData   = {6'h00, s_r.pendWrite, s_r.pendRead};
                    if (s_r.optWrite) begin
                      s_nxt.refused = 1'b1;
                    end else if (!s_r.wByte[fppc_pkg::BIT_OPT] && !s_r.in_circuit_comm &&
                                 s_r.cmd.addr < fppc_pkg::SECTOR0_END) begin
                      s_nxt.refused = 1'b1;
                    end else if (s_r.wByte[fppc_pkg::BIT_OPT]) begin
                      s_nxt.program_go     = 1'b1;
                      s_nxt.cmd.req = 1'b1;
                      if (s_r.optRead && !s_r.pendRead) begin
                        s_nxt.fl       = fppc_pkg::FL_MASS;
                        s_nxt.cmd.kind = fppc_pkg::OP_MASS_ERASE;
                      end else begin
                        s_nxt.fl       = fppc_pkg::FL_OP;
                        s_nxt.cmd.kind = fppc_pkg::OP_PROGRAM;
                      end
                    end else begin
                      s_nxt.program_go      = 1'b1;
                      s_nxt.cmd.req  = 1'b1;
                      s_nxt.fl       = fppc_pkg::FL_OP;
                      s_nxt.cmd.kind = (s_r.latchCount == '0) ?
                                       fppc_pkg::OP_ERASE : fppc_pkg::OP_PROGRAM;
                    end
                  end
                end
              end
              default: s_nxt.key = fppc_pkg::KEY_LOCKED;
            endcase
          end
          fppc_pkg::OFF_OPTION: begin
            s_nxt.pendRead  = s_r.wByte[fppc_pkg::OPT_PEND_READ];
            s_nxt.pendWrite = s_r.wByte[fppc_pkg::OPT_PEND_WRITE];
          end
          fppc_pkg::OFF_STATUS: begin
            if (s_r.wByte[fppc_pkg::ST_REFUSED] && s_nxt.refused == s_r.refused) begin
              s_nxt.refused = 1'b0;
            end
            if (s_r.wByte[fppc_pkg::ST_OVERRUN] && !overrunEvt) begin
              s_nxt.overrun = 1'b0;
            end
          end
          fppc_pkg::OFF_FLASH_ADDR: begin
            if (s_r.fl == fppc_pkg::FL_IDLE) begin
              s_nxt.cmd.addr = {s_r.wHigh, s_r.wByte};
            end
          end
          fppc_pkg::OFF_LATCH_DATA: begin
            if (s_r.latCtl && s_r.fl == fppc_pkg::FL_IDLE &&
                s_r.latchCount < fppc_pkg::MAX_BURST) begin
              s_nxt.latch.strobe = 1'b1;
              s_nxt.latch.index  = s_r.latchCount[4:0];
              s_nxt.latch.data   = s_r.wByte;
              s_nxt.latchCount   = s_r.latchCount + 6'h01;
            end else begin
              s_nxt.refused = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Register reads
    if (s_r.rValid && s_axi_rready) begin
      s_nxt.rValid = 1'b0;
    end
    if (s_r.arReady && s_axi_arvalid) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rResp  = isMapped(s_axi_araddr) ? fppc_pkg::RESP_OKAY : fppc_pkg::RESP_SLVERR;
      s_nxt.rData  = '0;
      case (s_axi_araddr)
        fppc_pkg::OFF_FLASH_CTRL_STATUS: s_nxt.rData[2:0] = {s_r.optRow, s_r.latCtl, s_r.program_go};
        fppc_pkg::OFF_OPTION: begin
          s_nxt.rData[fppc_pkg::OPT_READ_PROT]  = s_r.optRead;
          s_nxt.rData[fppc_pkg::OPT_WRITE_PROT] = s_r.optWrite;
          s_nxt.rData[fppc_pkg::OPT_PEND_READ]  = s_r.pendRead;
          s_nxt.rData[fppc_pkg::OPT_PEND_WRITE] = s_r.pendWrite;
        end
        fppc_pkg::OFF_STATUS: begin
          s_nxt.rData[fppc_pkg::ST_ICC]      = s_r.in_circuit_comm;
          s_nxt.rData[fppc_pkg::ST_TOOL]     = s_r.tool;
          s_nxt.rData[fppc_pkg::ST_BUSY]     = (s_r.fl != fppc_pkg::FL_IDLE);
          s_nxt.rData[fppc_pkg::ST_REFUSED]  = s_r.refused;
          s_nxt.rData[fppc_pkg::ST_OVERRUN]  = s_r.overrun;
          s_nxt.rData[fppc_pkg::ST_RX_VALID] = fifoOutValid;
          s_nxt.rData[fppc_pkg::ST_UNLOCKED] = (s_r.key == fppc_pkg::KEY_OPEN);
          s_nxt.rData[fppc_pkg::ST_RD_BLOCK] = s_r.rdBlock;
          s_nxt.rData[11:8]                  = fifoLevel;
        end
        fppc_pkg::OFF_RX_DATA: begin
          s_nxt.rData[8]   = fifoOutValid;
          s_nxt.rData[7:0] = fifoOutValid ? fifoOutData : 8'h00;
        end
        fppc_pkg::OFF_FLASH_ADDR: s_nxt.rData[12:0] = s_r.cmd.addr;
        fppc_pkg::OFF_LATCH_DATA: s_nxt.rData[5:0]  = s_r.latchCount;
        default: s_nxt.rData = '0;
      endcase
    end

    s_nxt.awReady = ~s_nxt.awHeld;
    s_nxt.wReady  = ~s_nxt.wHeld;
    s_nxt.arReady = ~s_nxt.rValid;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r            <= '0;
      s_r.pinSync    <= 3'h7;
      s_r.key        <= fppc_pkg::KEY_LOCKED;
      s_r.fl         <= fppc_pkg::FL_IDLE;
      {s_r.optRow, s_r.latCtl, s_r.program_go} <= fppc_pkg::FCS_RESET[2:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready       = s_r.awReady;
  assign s_axi_wready        = s_r.wReady;
  assign s_axi_bvalid        = s_r.bValid;
  assign s_axi_bresp         = s_r.bResp;
  assign s_axi_arready       = s_r.arReady;
  assign s_axi_rvalid        = s_r.rValid;
  assign s_axi_rdata         = s_r.rData;
  assign s_axi_rresp         = s_r.rResp;
  assign sysMemVector        = s_r.in_circuit_comm;
  assign inCircuitCommActive = s_r.in_circuit_comm;
  assign pinsReservedForTool = s_r.tool;
  assign readoutBlock        = s_r.rdBlock;
  assign flashCmd            = s_r.cmd;
  assign latchOut            = s_r.latch;
endmodule
`default_nettype wire

// file: test/fppc_tool_model.sv
// Purpose: Programming tool on the serial pins and reset pin
// Assumes: Serial clock idles low between frames, 48 ns period
// Notes:   Data line shows inverse of last bit once a byte ends
`default_nettype none
module fppc_tool_model (
  output logic progSerialClock, // Serial clock pin
  output logic progSerialData,  // Serial data pin
  output logic resetPin_n,      // Device reset pin
  output logic progSelect       // Tool attached
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {progSerialClock, progSerialData, resetPin_n, progSelect} = 4'h2;
  task automatic sendByte(input logic [7:0] b);
    #1;
    for (int i = 7; i >= 0; i--) begin
      progSerialData = b[i];
      #24 progSerialClock = 1'b1;
      #24 progSerialClock = 1'b0;
    end
    progSerialData = ~b[0];
  endtask
  task automatic enterSession(input logic [7:0] pat);
    #1 progSelect = 1'b1;
    resetPin_n = 1'b0;
    #100 sendByte(pat);
    #100 resetPin_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: test/fppc_checker.sv
// Purpose: Port assertions of the flash program/protect controller
// Assumes: One clock domain, bound to the top module
// Notes:   Ready inputs may be held high by the master
`default_nettype none
module fppc_checker (
  input wire logic clk,                           // Clock
  input wire logic rst_n,                         // Reset
  input wire logic s_axi_bvalid,                  // Write resp
  input wire logic s_axi_bready,                  // Write resp ready
  input wire logic s_axi_rvalid,                  // Read data
  input wire logic s_axi_rready,                  // Read ready
  input wire logic flashDone,                     // Op end
  input wire logic sysMemVector,                  // Vector select
  input wire logic inCircuitCommActive,           // Session
  input wire logic pinsReservedForTool,           // Pins withheld
  input wire logic readoutBlock,                  // Read block
  input wire fppc_pkg::fppc_flash_cmd_type flashCmd // Flash request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_VEC: assert property (sysMemVector == inCircuitCommActive) else $error("vector off");
  AST_PINS: assert property (inCircuitCommActive |-> pinsReservedForTool) else $error("pins");
  AST_RDBLK: assert property (readoutBlock |-> pinsReservedForTool) else $error("rd block");
  AST_BONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b");
  AST_RONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r");
  AST_REQ: assert property (flashCmd.req && !flashDone |=> flashCmd.req) else $error("req");
  AST_DONE: assert property (flashCmd.req && flashDone && flashCmd.kind != fppc_pkg::OP_MASS_ERASE
    |=> !flashCmd.req) else $error("req stays");
  AST_SECT: assert property ($rose(flashCmd.req) && !inCircuitCommActive && !flashCmd.optionRow
    |-> flashCmd.addr >= fppc_pkg::SECTOR0_END) else $error("sector 0 op");
endmodule
bind flash_program_protect_ctrl fppc_checker fppc_checker_i (.*);
`default_nettype wire

// file: test/flash_program_protect_ctrl_bench.sv
// Purpose: Bench of the flash program/protect controller
// Assumes: Bench answers flash ops by flashDone pulses
// Notes:   Response ready inputs held high throughout
`default_nettype none
module flash_program_protect_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, flashDone = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, optionByteIn = 8'h01;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic progSerialClock, progSerialData, progSelect, resetPin_n;
  logic sysMemVector, inCircuitCommActive, pinsReservedForTool, readoutBlock;
  fppc_pkg::fppc_flash_cmd_type flashCmd;
  fppc_pkg::fppc_latch_type latchOut;
  int bad_count = 0, tests_run = 0;
  flash_program_protect_ctrl flash_program_protect_ctrl_i (.*);
  fppc_tool_model fppc_tool_model_i (.*);
  always #2 clk = ~clk;
  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) return;
    end
    chk(1, 0);
    close_out();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        return;
      end
    end
    chk(1, 0);
    close_out();
  endtask
  task automatic key(input logic [7:0] d);
    wr(8'h00, fppc_pkg::KEY_FIRST);
    wr(8'h00, fppc_pkg::KEY_SECOND);
    wr(8'h00, d);
  endtask
  task automatic fl(input logic [1:0] k);
    for (int n = 0; n < 40 && flashCmd.req !== 1'b1; n++) @(posedge clk);
    chk({31'h0, flashCmd.req}, 32'h1);
    chk({30'h0, flashCmd.kind}, {30'h0, k});
    flashDone <= 1'b1;
    @(posedge clk);
    flashDone <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rc(8'h00, 32'h0, fppc_pkg::RESP_OKAY);
    rc(8'h40, 32'h0, fppc_pkg::RESP_SLVERR);
    fppc_tool_model_i.enterSession(fppc_pkg::ENTRY_PATTERN);
    for (int n = 0; n < 40 && inCircuitCommActive !== 1'b1; n++) @(posedge clk);
    chk({31'h0, inCircuitCommActive}, 32'h1);
    chk({30'h0, pinsReservedForTool, readoutBlock}, 32'h3);
    fppc_tool_model_i.sendByte(8'h3C);
    repeat (8) @(posedge clk);
    rc(8'h0C, 32'h13C, fppc_pkg::RESP_OKAY);
    wr(8'h00, fppc_pkg::KEY_FIRST);
    wr(8'h00, 8'h11);
    wr(8'h00, 8'h06);
    rc(8'h00, 32'h0, fppc_pkg::RESP_OKAY);
    key(8'h06);
    wr(8'h00, 8'h01);
    rc(8'h00, 32'h6, fppc_pkg::RESP_OKAY);
    wr(8'h04, 8'h00);
    key(8'h05);
    fl(fppc_pkg::OP_MASS_ERASE);
    fl(fppc_pkg::OP_PROGRAM);
    rc(8'h04, 32'h0, fppc_pkg::RESP_OKAY);
    rc(8'h00, 32'h4, fppc_pkg::RESP_OKAY);
    key(8'h02);
    wr(8'h14, 8'h5A);
    chk({18'h0, latchOut}, 32'h205A);
    rc(8'h14, 32'h1, fppc_pkg::RESP_OKAY);
    key(8'h03);
    fl(fppc_pkg::OP_PROGRAM);
    rc(8'h14, 32'h0, fppc_pkg::RESP_OKAY);
    wr(8'h04, 8'h20);
    key(8'h05);
    fl(fppc_pkg::OP_PROGRAM);
    rc(8'h04, 32'h22, fppc_pkg::RESP_OKAY);
    wr(8'h04, 8'h00);
    key(8'h05);
    rc(8'h04, 32'h02, fppc_pkg::RESP_OKAY);
    chk({31'h0, flashCmd.req}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
